// *** core/adc_ctl_regs.svh ***
// Register offsets, field positions, reset values and cycle counts
// of the converter control block.
// Assumes an 8-bit data-memory address and 8-bit register data.
`ifndef ADC_CTL_REGS_SVH
`define ADC_CTL_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RESULT_LOW_ADDR     8'h78
`define RESULT_HIGH_ADDR    8'h79
`define CONTROL_A_ADDR      8'h7a
`define CONTROL_B_ADDR      8'h7b
`define LAYOUT_ADDR         8'h7c
`define PIN_DISABLE_ADDR    8'h7e

// ****************************************************************
// Field positions
// ****************************************************************
`define CA_ENABLE_BIT       7
`define CA_START_BIT        6
`define CA_AUTO_BIT         5
`define CA_DONE_BIT         4
`define CA_IRQ_EN_BIT       3
`define CA_DIV_MSB          2
`define CA_DIV_LSB          0
`define CB_SRC_MSB          2
`define CB_SRC_LSB          0
`define LAYOUT_LEFT_BIT     5

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define BYTE_ZERO           8'h00
`define RESULT_ZERO         10'h000
`define SRC_FREE_RUN        3'h0
`define PAD_LEFT            6'h00
`define PAD_RIGHT           6'h00

// Converter clock cycles per conversion
`define FIRST_CONV_CYCLES   5'h19
`define NORMAL_CONV_CYCLES  5'h0d
`define CYCLE_ZERO          5'h00
`define CYCLE_ONE           5'h01

// Prescaler terminal counts (divisor minus one)
`define DIV_LIM_2           7'h01
`define DIV_LIM_4           7'h03
`define DIV_LIM_8           7'h07
`define DIV_LIM_16          7'h0f
`define DIV_LIM_32          7'h1f
`define DIV_LIM_64          7'h3f
`define DIV_LIM_128         7'h7f
`define DIV_CNT_ZERO        7'h00
`define DIV_CNT_ONE         7'h01

`endif

// *** core/adc_ctl_pkg.sv ***
// Types shared by the converter control modules.
// Assumes adc_ctl_regs.svh for all numeric constants.
package adc_ctl_pkg;

  typedef logic [7:0] byte_t;
  typedef logic [9:0] result_t;
  typedef logic [2:0] sel_t;

  // Trigger sources, codes 0 to 7
  typedef enum logic [2:0] {
    SRC_FREE_RUN   = 3'b000,
    SRC_COMPARATOR = 3'b001,
    SRC_EXT_INT0   = 3'b010,
    SRC_T0_COMPARE = 3'b011,
    SRC_T0_OVF     = 3'b100,
    SRC_T1_COMP_B  = 3'b101,
    SRC_T1_OVF     = 3'b110,
    SRC_T1_CAPTURE = 3'b111
  } trig_src_e;

  typedef enum logic [0:0] {
    SEQ_IDLE    = 1'b0,
    SEQ_CONVERT = 1'b1
  } seq_state_e;

endpackage

// *** core/conv_if.sv ***
// Signals between the control top, the prescaler and the sequencer.
// Assumes all three parties run on the same clock.
`timescale 1ns/100ps
`default_nettype none

interface conv_if;
  import adc_ctl_pkg::*;

  logic enable;
  sel_t div_sel;
  logic tick;
  logic start;
  logic busy;
  logic done;

  modport ctrl    (output enable, output div_sel, output start, input busy, input done);
  modport divider (input enable, input div_sel, output tick);
  modport seq     (input enable, input tick, input start, output busy, output done);
endinterface

`default_nettype wire

// *** core/conv_clock_divider.sv ***
// Prescaler making the converter clock tick from the system clock.
// Assumes a synchronised active-low reset from the top.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_regs.svh"

module conv_clock_divider (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control link
  conv_if.divider   link
);
  import adc_ctl_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_state_s;

  div_state_s s_r;
  div_state_s s_nxt;

  function automatic logic [6:0] div_limit(input sel_t code);
    case (code)
      3'h0:    div_limit = `DIV_LIM_2;
      3'h1:    div_limit = `DIV_LIM_2;
      3'h2:    div_limit = `DIV_LIM_4;
      3'h3:    div_limit = `DIV_LIM_8;
      3'h4:    div_limit = `DIV_LIM_16;
      3'h5:    div_limit = `DIV_LIM_32;
      3'h6:    div_limit = `DIV_LIM_64;
      default: div_limit = `DIV_LIM_128;
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!link.enable) begin
      s_nxt.cnt = `DIV_CNT_ZERO;
    // Compare with >= so a lowered divisor never strands the counter
    end else if (s_r.cnt >= div_limit(link.div_sel)) begin
      s_nxt.cnt  = `DIV_CNT_ZERO;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + `DIV_CNT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.tick = s_r.tick;
endmodule

`default_nettype wire

// *** core/conv_sequencer.sv ***
// Times one conversion in converter clock ticks.
// Assumes start is a one-cycle pulse given only while not busy.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_regs.svh"

module conv_sequencer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control link
  conv_if.seq       link
);
  import adc_ctl_pkg::*;

  typedef struct packed {
    seq_state_e state;
    logic [4:0] cnt;
    logic [4:0] limit;
    logic       initialized;
    logic       done;
  } seq_s;

  seq_s s_r;
  seq_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!link.enable) begin
      s_nxt.state       = SEQ_IDLE;
      s_nxt.cnt         = `CYCLE_ZERO;
      s_nxt.initialized = 1'b0;
    end else begin
      case (s_r.state)
        SEQ_IDLE: begin
          if (link.start) begin
            s_nxt.state = SEQ_CONVERT;
            s_nxt.cnt   = `CYCLE_ZERO;
            s_nxt.limit = s_r.initialized ? `NORMAL_CONV_CYCLES : `FIRST_CONV_CYCLES;
          end
        end
        SEQ_CONVERT: begin
          if (link.tick) begin
            if (s_r.cnt == s_r.limit - `CYCLE_ONE) begin
              s_nxt.state       = SEQ_IDLE;
              s_nxt.done        = 1'b1;
              s_nxt.initialized = 1'b1;
            end else begin
              s_nxt.cnt = s_r.cnt + `CYCLE_ONE;
            end
          end
        end
        default: begin
          s_nxt.state = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.busy = (s_r.state == SEQ_CONVERT);
  assign link.done = s_r.done;
endmodule

`default_nettype wire

// *** core/adc_control_result_regs.sv ***
// Control, status, trigger and result registers of a 10-bit converter.
// Assumes same-clock trigger flags, result and interrupt handshake;
// analog pins arrive asynchronous and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_regs.svh"

module adc_control_result_regs (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire adc_ctl_pkg::byte_t   wr_data,
  input  wire logic                 wr_strobe,
  input  wire logic                 rd_strobe,
  output var  adc_ctl_pkg::byte_t   rd_data,
  // Converter front end
  input  wire adc_ctl_pkg::result_t sample_value,
  output var  logic                 converter_on,
  output var  logic                 converting,
  // Trigger flags for codes 1 to 7
  input  wire logic [6:0]           trigger_flags,
  // Processor interrupt handshake
  input  wire logic                 global_irq_enable,
  input  wire logic                 irq_vector_taken,
  output var  logic                 irq_request,
  // Analog pins and port input path
  input  wire logic [7:0]           pin_level,
  output var  logic [7:0]           input_buffer_off,
  output var  logic [7:0]           port_pin_value
);
  import adc_ctl_pkg::*;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  conv_if link ();

  conv_clock_divider u_divider (
    .clk   (clk),
    .rst_n (rst_n_r),
    .link  (link)
  );

  conv_sequencer u_sequencer (
    .clk   (clk),
    .rst_n (rst_n_r),
    .link  (link)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    byte_t     rdata;
    logic      enable;
    logic      auto_trig;
    logic      done_flag;
    logic      irq_en;
    sel_t      div_sel;
    trig_src_e src;
    logic      left_adj;
    byte_t     pin_disable;
    result_t   result;
    logic      lock;
    logic      start;
    logic      trig_prev;
    logic      irq;
    logic      busy;
    byte_t     pin_meta;
    byte_t     pin_sync;
    byte_t     pin_value;
  } ctl_s;

  ctl_s s_r;
  ctl_s s_nxt;

  // ****************************************************************
  // Decode and derived terms
  // ****************************************************************
  logic    wr_ctrl_a;
  logic    wr_ctrl_b;
  logic    wr_layout;
  logic    wr_disable;
  logic    rd_low;
  logic    rd_high;
  logic    enable_next;
  logic    trig_level;
  logic    trig_edge;
  logic    auto_start;
  logic    sw_start;
  logic    flag_clear;
  byte_t   low_view;
  byte_t   high_view;
  byte_t   rd_mux;

  assign wr_ctrl_a  = wr_strobe && (addr == `CONTROL_A_ADDR);
  assign wr_ctrl_b  = wr_strobe && (addr == `CONTROL_B_ADDR);
  assign wr_layout  = wr_strobe && (addr == `LAYOUT_ADDR);
  assign wr_disable = wr_strobe && (addr == `PIN_DISABLE_ADDR);
  assign rd_low     = rd_strobe && (addr == `RESULT_LOW_ADDR);
  assign rd_high    = rd_strobe && (addr == `RESULT_HIGH_ADDR);

  assign enable_next = wr_ctrl_a ? wr_data[`CA_ENABLE_BIT] : s_r.enable;

  always_comb begin
    // free-running code has no level of its own
    if (s_r.src == SRC_FREE_RUN) begin
      trig_level = 1'b0;
    end else begin
      trig_level = trigger_flags[s_r.src - 3'h1];
    end
  end

  assign trig_edge = trig_level && !s_r.trig_prev;

  assign auto_start = s_r.auto_trig &&
                      ((s_r.src != SRC_FREE_RUN) ? trig_edge : link.done);

  assign sw_start = wr_ctrl_a && wr_data[`CA_START_BIT];

  assign flag_clear = irq_vector_taken || (wr_ctrl_a && wr_data[`CA_DONE_BIT]);

  assign low_view  = s_r.left_adj ? {s_r.result[1:0], `PAD_LEFT} : s_r.result[7:0];
  assign high_view = s_r.left_adj ? s_r.result[9:2] : {`PAD_RIGHT, s_r.result[9:8]};

  // ****************************************************************
  // Register read views
  // ****************************************************************
  // Built from the field positions, so a moved field moves its read bit
  byte_t   ctrl_a_view;
  byte_t   ctrl_b_view;
  byte_t   layout_view;

  always_comb begin
    // Reserved positions read zero
    ctrl_a_view                          = `BYTE_ZERO;
    ctrl_a_view[`CA_ENABLE_BIT]          = s_r.enable;
    ctrl_a_view[`CA_START_BIT]           = s_r.busy || s_r.start;
    ctrl_a_view[`CA_AUTO_BIT]            = s_r.auto_trig;
    ctrl_a_view[`CA_DONE_BIT]            = s_r.done_flag;
    ctrl_a_view[`CA_IRQ_EN_BIT]          = s_r.irq_en;
    ctrl_a_view[`CA_DIV_MSB:`CA_DIV_LSB] = s_r.div_sel;
    ctrl_b_view                          = `BYTE_ZERO;
    ctrl_b_view[`CB_SRC_MSB:`CB_SRC_LSB] = s_r.src;
    layout_view                          = `BYTE_ZERO;
    layout_view[`LAYOUT_LEFT_BIT]        = s_r.left_adj;
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Reads have no side effect here; only the result bytes lock

  always_comb begin
    case (addr)
      `RESULT_LOW_ADDR:  rd_mux = low_view;
      `RESULT_HIGH_ADDR: rd_mux = high_view;
      `CONTROL_A_ADDR:   rd_mux = ctrl_a_view;
      `CONTROL_B_ADDR:   rd_mux = ctrl_b_view;
      `LAYOUT_ADDR:      rd_mux = layout_view;
      `PIN_DISABLE_ADDR: rd_mux = s_r.pin_disable;
      default:           rd_mux = `BYTE_ZERO;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;

    // Read data lives for exactly the cycle after the strobe
    s_nxt.rdata = rd_strobe ? rd_mux : `BYTE_ZERO;

    if (wr_ctrl_a) begin
      s_nxt.enable    = wr_data[`CA_ENABLE_BIT];
      s_nxt.auto_trig = wr_data[`CA_AUTO_BIT];
      s_nxt.irq_en    = wr_data[`CA_IRQ_EN_BIT];
      s_nxt.div_sel   = wr_data[`CA_DIV_MSB:`CA_DIV_LSB];
    end
    if (wr_ctrl_b) begin
      s_nxt.src = trig_src_e'(wr_data[`CB_SRC_MSB:`CB_SRC_LSB]);
    end
    if (wr_layout) begin
      s_nxt.left_adj = wr_data[`LAYOUT_LEFT_BIT];
    end
    if (wr_disable) begin
      s_nxt.pin_disable = wr_data;
    end

    // flag set on completion, set beats clear
    s_nxt.done_flag = link.done || (s_r.done_flag && !flag_clear);

    // low read locks, high read unlocks
    if (rd_high) begin
      s_nxt.lock = 1'b0;
    end else if (rd_low) begin
      s_nxt.lock = 1'b1;
    end

    // front end code passed unchanged, kept while the low byte locks
    if (link.done && !s_r.lock) begin
      s_nxt.result = sample_value;
    end

    s_nxt.trig_prev = trig_level;
    s_nxt.busy      = link.busy || link.start;

    // One-cycle start pulse; a start while converting is dropped
    s_nxt.start = enable_next && !s_r.start && !link.busy && (sw_start || auto_start);
    if (!enable_next) begin
      s_nxt.start = 1'b0;
    end

    s_nxt.irq = s_r.done_flag && s_r.irq_en && global_irq_enable;

    s_nxt.pin_meta  = pin_level;
    s_nxt.pin_sync  = s_r.pin_meta;
    s_nxt.pin_value = s_r.pin_sync & ~s_r.pin_disable;
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // disable reaches the sequencer in the cycle after the write
  assign link.enable  = s_r.enable;
  assign link.div_sel = s_r.div_sel;
  assign link.start   = s_r.start;

  assign rd_data          = s_r.rdata;
  assign converter_on     = s_r.enable;
  assign converting       = s_r.busy;
  assign irq_request      = s_r.irq;
  assign input_buffer_off = s_r.pin_disable;
  assign port_pin_value   = s_r.pin_value;
endmodule

`default_nettype wire

// *** dv/adc_control_result_regs_monitor.sv ***
// Port-level checker for the converter control block.
// Assumes the register map of adc_ctl_regs.svh; attached by bind.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_regs.svh"

module adc_control_result_regs_monitor (
  // Clock and reset
  input wire logic               clk,
  input wire logic               arst_n,
  // Register port
  input wire logic [7:0]         addr,
  input wire adc_ctl_pkg::byte_t wr_data,
  input wire logic               wr_strobe,
  input wire logic               rd_strobe,
  input wire adc_ctl_pkg::byte_t rd_data,
  // Status, interrupt and pins
  input wire logic               converter_on,
  input wire logic               converting,
  input wire logic               global_irq_enable,
  input wire logic               irq_vector_taken,
  input wire logic               irq_request,
  input wire logic [7:0]         input_buffer_off,
  input wire logic [7:0]         port_pin_value
);
  import adc_ctl_pkg::*;

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Quiet around the clear, so no completion can re-set the flag
  sequence s_idle_vec;
    !converting ##1 (irq_vector_taken && !converting) ##1 !converting;
  endsequence
  sequence s_idle_w1c;
    !converting ##1 (wr_strobe && addr == `CONTROL_A_ADDR && wr_data[`CA_DONE_BIT])
      ##1 !converting;
  endsequence
  sequence s_pin_wr_once;
    (wr_strobe && addr == `PIN_DISABLE_ADDR) ##1 !(wr_strobe && addr == `PIN_DISABLE_ADDR);
  endsequence
  sequence s_ctla_wr_once;
    (wr_strobe && addr == `CONTROL_A_ADDR) ##1 !(wr_strobe && addr == `CONTROL_A_ADDR);
  endsequence

  a_irq_needs_global: assert property (irq_request |-> $past(global_irq_enable))
    else $error("interrupt request without global enable");
  a_vector_clears_irq: assert property (s_idle_vec |-> ##1 !irq_request)
    else $error("interrupt request survives vector");
  a_flag_w1c_irq: assert property (s_idle_w1c |-> ##1 !irq_request)
    else $error("interrupt request survives flag clear");
  a_pin_masked_zero: assert property (
    (port_pin_value & input_buffer_off & $past(input_buffer_off)) == 8'h00)
    else $error("disabled pin reads nonzero");
  a_pin_disable_load: assert property (
    s_pin_wr_once |-> ##1 input_buffer_off == $past(wr_data, 2))
    else $error("input buffer disable not loaded");
  a_enable_follows: assert property (
    s_ctla_wr_once |-> ##1 converter_on == $past(wr_data[`CA_ENABLE_BIT], 2))
    else $error("converter enable not loaded");
  a_abort_on_off: assert property ($fell(converter_on) |-> ##[0:3] !converting)
    else $error("conversion not aborted");
  a_start_needs_on: assert property ($rose(converting) |-> converter_on)
    else $error("conversion started while off");
  a_rd_data_idle: assert property (!$past(rd_strobe) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
endmodule

bind adc_control_result_regs adc_control_result_regs_monitor u_mon (
  .clk, .arst_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .converter_on,
  .converting, .global_irq_enable, .irq_vector_taken, .irq_request, .input_buffer_off,
  .port_pin_value
);

`default_nettype wire

// *** dv/test_adc_control_result_regs.sv ***
// Self-checking bench for the converter control block.
// Assumes the bound checker and the register map header.
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctl_regs.svh"

module test_adc_control_result_regs;
  import adc_ctl_pkg::*;

  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  byte_t       wr_data = 8'h00;
  logic        wr_strobe = 1'b0;
  logic        rd_strobe = 1'b0;
  byte_t       rd_data;
  result_t     sample_value = 10'h000;
  logic        converter_on;
  logic        converting;
  logic [6:0]  trigger_flags = 7'h00;
  logic        global_irq_enable = 1'b0;
  logic        irq_vector_taken = 1'b0;
  logic        irq_request;
  logic [7:0]  pin_level = 8'h00;
  logic [7:0]  input_buffer_off;
  logic [7:0]  port_pin_value;
  int          failures = 0;
  int          tests_run = 0;
  int          divs [8] = '{2, 2, 4, 8, 16, 32, 64, 128};

  always #2 clk = ~clk;

  adc_control_result_regs DUT (
    .clk, .arst_n, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .sample_value,
    .converter_on, .converting, .trigger_flags, .global_irq_enable, .irq_vector_taken,
    .irq_request, .pin_level, .input_buffer_off, .port_pin_value
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input byte_t got, input byte_t exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Phase of the free-running prescaler leaves up to one divisor of slack
  task automatic chk_len(input int n, input int t, input int d);
    tests_run++;
    if (n < (t - 1) * d - 4 || n > t * d + 4) begin
      failures++;
      $display("[ERR] %0t conversion length %0d", $time, n);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input byte_t d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input byte_t m, input byte_t e);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    chk(rd_data & m, e);
  endtask
  task automatic conv_len(output int n);
    n = 0;
    for (int i = 0; i < 20; i++) if (converting !== 1'b1) settle(1);
    while (converting === 1'b1 && n < 4000) begin
      settle(1);
      n++;
    end
  endtask
  task automatic pulse_vec;
    @(posedge clk);
    irq_vector_taken <= 1'b1;
    @(posedge clk);
    irq_vector_taken <= 1'b0;
  endtask
  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(`RESULT_LOW_ADDR, 8'hff, 8'h00);
    rd(`RESULT_HIGH_ADDR, 8'hff, 8'h00);
    rd(`CONTROL_A_ADDR, 8'hff, 8'h00);
    rd(`CONTROL_B_ADDR, 8'hff, 8'h00);
    rd(`PIN_DISABLE_ADDR, 8'hff, 8'h00);
    rd(8'h70, 8'hff, 8'h00);
    pin_level <= 8'hff;
    wr(`PIN_DISABLE_ADDR, 8'ha5);
    settle(5);
    chk(input_buffer_off, 8'ha5);
    chk(port_pin_value, 8'h5a);
    rd(`PIN_DISABLE_ADDR, 8'hff, 8'ha5);
    fin("reset_pins");
  endtask
  task automatic t_conv;
    int n;
    sample_value <= 10'h2b7;
    global_irq_enable <= 1'b1;
    wr(`CONTROL_A_ADDR, 8'hc9);
    conv_len(n);
    chk_len(n, 25, 2);
    settle(4);
    chk({7'h00, irq_request}, 8'h01);
    rd(`CONTROL_A_ADDR, 8'h50, 8'h10);
    rd(`RESULT_LOW_ADDR, 8'hff, 8'hb7);
    rd(`RESULT_HIGH_ADDR, 8'hff, 8'h02);
    sample_value <= 10'h155;
    wr(`CONTROL_A_ADDR, 8'hd9);
    settle(1);
    chk({7'h00, irq_request}, 8'h00);
    conv_len(n);
    chk_len(n, 13, 2);
    settle(4);
    wr(`LAYOUT_ADDR, 8'h20);
    rd(`RESULT_LOW_ADDR, 8'hff, 8'h40);
    rd(`RESULT_HIGH_ADDR, 8'hff, 8'h55);
    wr(`LAYOUT_ADDR, 8'h00);
    rd(`RESULT_LOW_ADDR, 8'hff, 8'h55);
    sample_value <= 10'h0aa;
    wr(`CONTROL_A_ADDR, 8'hd9);
    conv_len(n);
    settle(4);
    rd(`RESULT_HIGH_ADDR, 8'hff, 8'h01);
    rd(`RESULT_LOW_ADDR, 8'hff, 8'h55);
    rd(`RESULT_HIGH_ADDR, 8'hff, 8'h01);
    fin("conversion");
  endtask
  task automatic t_irq;
    global_irq_enable <= 1'b0;
    settle(3);
    chk({7'h00, irq_request}, 8'h00);
    global_irq_enable <= 1'b1;
    wr(`CONTROL_A_ADDR, 8'h89);
    settle(3);
    chk({7'h00, irq_request}, 8'h01);
    wr(`CONTROL_A_ADDR, 8'h81);
    settle(3);
    chk({7'h00, irq_request}, 8'h00);
    wr(`CONTROL_A_ADDR, 8'h89);
    pulse_vec();
    settle(3);
    chk({7'h00, irq_request}, 8'h00);
    rd(`CONTROL_A_ADDR, 8'h10, 8'h00);
    fin("interrupt");
  endtask
  task automatic t_abort;
    int n;
    wr(`CONTROL_A_ADDR, 8'hc9);
    settle(6);
    rd(`CONTROL_A_ADDR, 8'h40, 8'h40);
    wr(`CONTROL_A_ADDR, 8'h09);
    settle(8);
    chk({6'h00, converter_on, converting}, 8'h00);
    rd(`CONTROL_A_ADDR, 8'h50, 8'h00);
    wr(`CONTROL_A_ADDR, 8'hc9);
    conv_len(n);
    chk_len(n, 25, 2);
    settle(4);
    fin("abort");
  endtask
  task automatic t_auto;
    int n;
    wr(`CONTROL_A_ADDR, 8'ha9);
    settle(10);
    chk({7'h00, converting}, 8'h00);
    pulse_vec();
    for (int c = 1; c < 8; c++) begin
      trigger_flags <= 7'h00;
      wr(`CONTROL_B_ADDR, 8'(c));
      trigger_flags <= ~(7'h01 << (c - 1));
      settle(8);
      chk({7'h00, converting}, 8'h00);
      trigger_flags <= 7'h7f;
      conv_len(n);
      chk_len(n, 13, 2);
    end
    trigger_flags <= 7'h02;
    wr(`CONTROL_B_ADDR, 8'h02);
    conv_len(n);
    chk_len(n, 13, 2);
    wr(`CONTROL_A_ADDR, 8'h89);
    trigger_flags <= 7'h00;
    settle(2);
    trigger_flags <= 7'h7f;
    settle(8);
    chk({7'h00, converting}, 8'h00);
    wr(`CONTROL_B_ADDR, 8'h00);
    wr(`CONTROL_A_ADDR, 8'he9);
    conv_len(n);
    settle(3);
    chk({7'h00, converting}, 8'h01);
    wr(`CONTROL_A_ADDR, 8'h09);
    fin("auto_trigger");
  endtask
  task automatic t_prescale;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(`CONTROL_A_ADDR, 8'hd0 | 8'(c));
      conv_len(n);
      chk_len(n, (c == 0) ? 25 : 13, divs[c]);
      settle(4);
    end
    // Read-modify-write setting the interrupt enable writes the set flag back
    rd(`CONTROL_A_ADDR, 8'h10, 8'h10);
    wr(`CONTROL_A_ADDR, 8'h9f);
    rd(`CONTROL_A_ADDR, 8'h18, 8'h08);
    fin("prescaler");
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_conv();
    t_irq();
    t_abort();
    t_auto();
    t_prescale();
    end_sim();
  end
  // About six times the expected run length
  initial begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule

`default_nettype wire
